// file: inc/adc_pair_trigger_cfg.svh
// offsets, field positions, reset values and bus answers of the pair trigger control
`ifndef ADC_PAIR_TRIGGER_CFG_SVH
`define ADC_PAIR_TRIGGER_CFG_SVH

// ==========================================================
// register byte offsets
`define OFF_PAIR_LOW    8'h00
`define OFF_PAIR_MID    8'h04
`define OFF_GLOBAL_CTRL 8'h08
`define OFF_IRQ_STATUS  8'h0C
`define OFF_IRQ_MASK    8'h10

// ==========================================================
// fields inside one pair byte
`define FLD_IRQ_EN      7
`define FLD_PENDING     6
`define FLD_SOFT_TRIG   5
`define FLD_SRC_MSB     4

// ==========================================================
// fields of the global control register
`define FLD_GLOBAL_SOFT 10
`define FLD_ORDER       6

// ==========================================================
// reset values
`define RST_PAIR_CTRL   16'h0000
`define RST_GLOBAL_CTRL 2'h0
`define RST_IRQ         4'h0

// ==========================================================
// bus answers
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// file: inc/adc_pair_trigger_pkg.sv
// types shared by the pair trigger control and its conversion scheduler
package adc_pair_trigger_pkg;

   // ==========================================================
   // trigger source codes
   typedef enum logic [4:0] {
      SRC_OFF         = 5'h00,
      SRC_SOFT        = 5'h01,
      SRC_GLOBAL      = 5'h02,
      SRC_PWM_SPECIAL = 5'h03,
      SRC_PWM1        = 5'h04,
      SRC_PWM2        = 5'h05,
      SRC_PWM3        = 5'h06,
      SRC_PWM4        = 5'h07,
      SRC_TMR1        = 5'h0C,
      SRC_TMR2        = 5'h0D,
      SRC_ILIM1       = 5'h0E,
      SRC_ILIM2       = 5'h0F,
      SRC_ILIM3       = 5'h10,
      SRC_ILIM4       = 5'h11,
      SRC_FAULT1      = 5'h16,
      SRC_FAULT2      = 5'h17,
      SRC_FAULT3      = 5'h18,
      SRC_FAULT4      = 5'h19
   } trig_src_t;

   // ==========================================================
   // scheduler states
   typedef enum logic [1:0] {
      SCH_IDLE   = 2'b00,
      SCH_FIRST  = 2'b01,
      SCH_SECOND = 2'b10
   } sched_state_t;

endpackage : adc_pair_trigger_pkg

// file: rtl/adc_pair_conv_sched.sv
// shared converter scheduler: runs pending pairs one at a time, two inputs each
`timescale 1ns/10ps
`default_nettype none

module adc_pair_conv_sched (
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst,
   input  wire logic [3:0] i_pending,
   input  wire logic       i_order,
   input  wire logic       i_conv_done,
   output logic            o_conv_start,
   output logic      [3:0] o_conv_channel,
   output logic      [3:0] o_pair_done,
   output logic            o_busy
);
   import adc_pair_trigger_pkg::*;

   sched_state_t state_q;
   sched_state_t state_d;
   logic [1:0]   pair_q;
   logic [1:0]   pair_d;
   logic         start_q;
   logic         start_d;
   logic [3:0]   chan_q;
   logic [3:0]   chan_d;
   logic [1:0]   pick;

   // ==========================================================
   // lowest numbered pending pair goes first
   assign pick = i_pending[0] ? 2'd0 :
                 i_pending[1] ? 2'd1 :
                 i_pending[2] ? 2'd2 : 2'd3;

   always_comb begin
      state_d = state_q;
      pair_d  = pair_q;
      start_d = 1'b0;
      chan_d  = chan_q;
      case (state_q)
         SCH_IDLE: begin
            if (|i_pending) begin
               pair_d  = pick;
               start_d = 1'b1;
               chan_d  = {1'b0, pick, i_order};
               state_d = SCH_FIRST;
            end
         end
         SCH_FIRST: begin
            if (i_conv_done) begin
               start_d = 1'b1;
               chan_d  = {1'b0, pair_q, ~i_order};
               state_d = SCH_SECOND;
            end
         end
         SCH_SECOND: begin
            if (i_conv_done) begin
               state_d = SCH_IDLE;
            end
         end
         default: begin
            state_d = SCH_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         state_q <= SCH_IDLE;
         pair_q  <= 2'h0;
         start_q <= 1'b0;
         chan_q  <= 4'h0;
      end else begin
         state_q <= state_d;
         pair_q  <= pair_d;
         start_q <= start_d;
         chan_q  <= chan_d;
      end
   end

   // both inputs done: report the pair
   assign o_pair_done    = (state_q == SCH_SECOND && i_conv_done) ?
                           (4'h1 << pair_q) : 4'h0;
   assign o_conv_start   = start_q;
   assign o_conv_channel = chan_q;
   assign o_busy         = (state_q != SCH_IDLE);

endmodule : adc_pair_conv_sched

`default_nettype wire

// file: rtl/adc_pair_trigger_control.sv
// pair trigger control: source selection, pending flags, interrupts, AXI4-Lite registers
//
// Summary of operation
// - source zero disables the pair
// - codes 1,2 pick own or global software
// - code 3 special event, 4-7 PWM generators
// - codes 12,13 pick timer period matches
// - codes 14-17 pick current-limit triggers
// - codes 22-25 pick fault triggers
// - selected trigger sets the pending flag
// - both conversions done clears pending
// - interrupt enable raises request on completion
// - software bit starts only if selected
// - busy converter holds request until free
// - software bit clears when pending sets
// - byte holds enable, pending, soft, source
// - pairs 0,1 low register; 2,3 mid
// - all pair controls reset to zero
// - order bit picks which input first
`timescale 1ns/10ps
`default_nettype none
`include "adc_pair_trigger_cfg.svh"

module adc_pair_trigger_control (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   // AXI4-Lite slave
   input  wire logic  [7:0] i_s_axi_awaddr,
   input  wire logic        i_s_axi_awvalid,
   output logic             o_s_axi_awready,
   input  wire logic [31:0] i_s_axi_wdata,
   input  wire logic  [3:0] i_s_axi_wstrb,
   input  wire logic        i_s_axi_wvalid,
   output logic             o_s_axi_wready,
   output logic       [1:0] o_s_axi_bresp,
   output logic             o_s_axi_bvalid,
   input  wire logic        i_s_axi_bready,
   input  wire logic  [7:0] i_s_axi_araddr,
   input  wire logic        i_s_axi_arvalid,
   output logic             o_s_axi_arready,
   output logic      [31:0] o_s_axi_rdata,
   output logic       [1:0] o_s_axi_rresp,
   output logic             o_s_axi_rvalid,
   input  wire logic        i_s_axi_rready,
   // hardware trigger pulses
   input  wire logic        i_pwm_special,
   input  wire logic  [3:0] i_pwm_trig,
   input  wire logic  [1:0] i_tmr_period,
   input  wire logic  [3:0] i_pwm_ilim,
   input  wire logic  [3:0] i_pwm_fault,
   // shared converter
   output logic             o_conv_start,
   output logic       [3:0] o_conv_channel,
   input  wire logic        i_conv_done,
   output logic             o_conv_busy,
   // interrupt
   output logic             o_irq
);
   import adc_pair_trigger_pkg::*;

   // ==========================================================
   // trigger source decode
   function automatic logic sel_event(input logic [4:0] src,
                                      input logic sw,
                                      input logic [15:0] ev);
      logic hit;
      hit = 1'b0;
      case (src)
         SRC_SOFT:        hit = sw;
         SRC_GLOBAL:      hit = ev[0];
         SRC_PWM_SPECIAL: hit = ev[1];
         SRC_PWM1:        hit = ev[2];
         SRC_PWM2:        hit = ev[3];
         SRC_PWM3:        hit = ev[4];
         SRC_PWM4:        hit = ev[5];
         SRC_TMR1:        hit = ev[6];
         SRC_TMR2:        hit = ev[7];
         SRC_ILIM1:       hit = ev[8];
         SRC_ILIM2:       hit = ev[9];
         SRC_ILIM3:       hit = ev[10];
         SRC_ILIM4:       hit = ev[11];
         SRC_FAULT1:      hit = ev[12];
         SRC_FAULT2:      hit = ev[13];
         SRC_FAULT3:      hit = ev[14];
         SRC_FAULT4:      hit = ev[15];
         SRC_OFF:         hit = 1'b0;
         default:         hit = 1'b0;
      endcase
      return hit;
   endfunction : sel_event

   // pair byte as software sees it
   function automatic logic [7:0] pair_byte(input logic ien,
                                            input logic pend,
                                            input logic sw,
                                            input logic [4:0] src);
      return {ien, pend, sw, src};
   endfunction : pair_byte

   // ==========================================================
   // state
   logic [3:0]      ien_q;
   logic [3:0]      ien_d;
   logic [3:0]      pend_q;
   logic [3:0]      pend_d;
   logic [3:0]      sw_q;
   logic [3:0]      sw_d;
   logic [3:0][4:0] src_q;
   logic [3:0][4:0] src_d;
   logic            gsw_q;
   logic            gsw_d;
   logic            gsw_prev_q;
   logic            order_q;
   logic            order_d;
   logic [3:0]      irq_stat_q;
   logic [3:0]      irq_stat_d;
   logic [3:0]      irq_mask_q;
   logic [3:0]      irq_mask_d;
   logic [3:0]      pair_hit;
   logic [3:0]      pair_done;
   logic [15:0]     events;

   // bus state
   logic            aw_have_q;
   logic [7:0]      aw_addr_q;
   logic            w_have_q;
   logic [31:0]     wdata_q;
   logic [3:0]      wstrb_q;
   logic            bvalid_q;
   logic [1:0]      bresp_q;
   logic            rvalid_q;
   logic [31:0]     rdata_q;
   logic [1:0]      rresp_q;

   // ==========================================================
   // write address and data are taken independently
   wire aw_take = i_s_axi_awvalid & o_s_axi_awready;
   wire w_take  = i_s_axi_wvalid & o_s_axi_wready;
   wire ar_take = i_s_axi_arvalid & o_s_axi_arready;
   wire wr_en   = aw_have_q & w_have_q;

   assign o_s_axi_awready = ~aw_have_q & ~bvalid_q;
   assign o_s_axi_wready  = ~w_have_q & ~bvalid_q;
   assign o_s_axi_arready = ~rvalid_q;

   // write decode
   wire wr_low    = wr_en & (aw_addr_q == `OFF_PAIR_LOW);
   wire wr_mid    = wr_en & (aw_addr_q == `OFF_PAIR_MID);
   wire wr_glob   = wr_en & (aw_addr_q == `OFF_GLOBAL_CTRL);
   wire wr_stat   = wr_en & (aw_addr_q == `OFF_IRQ_STATUS);
   wire wr_mask   = wr_en & (aw_addr_q == `OFF_IRQ_MASK);
   wire wr_mapped = wr_low | wr_mid | wr_glob | wr_stat | wr_mask;

   // read decode
   wire rd_low    = (i_s_axi_araddr == `OFF_PAIR_LOW);
   wire rd_mid    = (i_s_axi_araddr == `OFF_PAIR_MID);
   wire rd_glob   = (i_s_axi_araddr == `OFF_GLOBAL_CTRL);
   wire rd_stat   = (i_s_axi_araddr == `OFF_IRQ_STATUS);
   wire rd_mask   = (i_s_axi_araddr == `OFF_IRQ_MASK);
   wire rd_mapped = rd_low | rd_mid | rd_glob | rd_stat | rd_mask;

   // read values, unused bits zero
   wire [31:0] val_low  = {16'h0000,
                           pair_byte(ien_q[1], pend_q[1], sw_q[1], src_q[1]),
                           pair_byte(ien_q[0], pend_q[0], sw_q[0], src_q[0])};
   wire [31:0] val_mid  = {16'h0000,
                           pair_byte(ien_q[3], pend_q[3], sw_q[3], src_q[3]),
                           pair_byte(ien_q[2], pend_q[2], sw_q[2], src_q[2])};
   wire [31:0] val_glob = (32'(gsw_q) << `FLD_GLOBAL_SOFT) |
                          (32'(order_q) << `FLD_ORDER);
   wire [31:0] val_stat = {28'h0000000, irq_stat_q};
   wire [31:0] val_mask = {28'h0000000, irq_mask_q};
   wire [31:0] rd_word  = rd_low  ? val_low  :
                          rd_mid  ? val_mid  :
                          rd_glob ? val_glob :
                          rd_stat ? val_stat :
                          rd_mask ? val_mask : 32'h00000000;

   // ==========================================================
   // trigger events; global bit counts once per rising edge
   wire gsw_edge = gsw_q & ~gsw_prev_q;

   assign events = {i_pwm_fault, i_pwm_ilim, i_tmr_period,
                    i_pwm_trig, i_pwm_special, gsw_edge};

   // ==========================================================
   // per pair control update
   always_comb begin
      ien_d    = ien_q;
      sw_d     = sw_q;
      src_d    = src_q;
      pend_d   = pend_q;
      pair_hit = 4'h0;
      for (int p = 0; p < 4; p++) begin
         logic       sel;
         logic [7:0] wb;
         sel = ((p / 2) == 1) ? wr_mid : wr_low;
         wb  = wdata_q[8 * (p % 2) +: 8];
         if (sel & wstrb_q[p % 2]) begin
            ien_d[p] = wb[`FLD_IRQ_EN];
            sw_d[p]  = wb[`FLD_SOFT_TRIG];
            src_d[p] = wb[`FLD_SRC_MSB:0];
         end
         pair_hit[p] = sel_event(src_q[p], sw_q[p], events);
         if (pair_hit[p]) begin
            sw_d[p] = 1'b0;
         end
         pend_d[p] = pair_hit[p] | (pend_q[p] & ~pair_done[p]);
      end
   end

   // global control
   assign gsw_d   = (wr_glob & wstrb_q[1]) ? wdata_q[`FLD_GLOBAL_SOFT] : gsw_q;
   assign order_d = (wr_glob & wstrb_q[0]) ? wdata_q[`FLD_ORDER] : order_q;

   // sticky completion status, set wins over write-one clear
   wire [3:0] stat_clr = (wr_stat & wstrb_q[0]) ? wdata_q[3:0] : 4'h0;
   wire [3:0] stat_set = pair_done & ien_q;
   assign irq_stat_d = (irq_stat_q & ~stat_clr) | stat_set;
   assign irq_mask_d = (wr_mask & wstrb_q[0]) ? wdata_q[3:0] : irq_mask_q;

   // ==========================================================
   // control registers
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         ien_q      <= 4'h0;
         pend_q     <= 4'h0;
         sw_q       <= 4'h0;
         src_q      <= 20'h00000;
         gsw_q      <= 1'b0;
         gsw_prev_q <= 1'b0;
         order_q    <= 1'b0;
         irq_stat_q <= `RST_IRQ;
         irq_mask_q <= `RST_IRQ;
      end else begin
         ien_q      <= ien_d;
         pend_q     <= pend_d;
         sw_q       <= sw_d;
         src_q      <= src_d;
         gsw_q      <= gsw_d;
         gsw_prev_q <= gsw_q;
         order_q    <= order_d;
         irq_stat_q <= irq_stat_d;
         irq_mask_q <= irq_mask_d;
      end
   end

   // ==========================================================
   // write channel registers
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_have_q  <= 1'b0;
         wdata_q   <= 32'h00000000;
         wstrb_q   <= 4'h0;
      end else begin
         if (aw_take) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= i_s_axi_awaddr;
         end else if (wr_en) begin
            aw_have_q <= 1'b0;
         end
         if (w_take) begin
            w_have_q <= 1'b1;
            wdata_q  <= i_s_axi_wdata;
            wstrb_q  <= i_s_axi_wstrb;
         end else if (wr_en) begin
            w_have_q <= 1'b0;
         end
      end
   end

   // write response
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `RESP_OKAY;
      end else if (wr_en) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (i_s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // read data
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h00000000;
         rresp_q  <= `RESP_OKAY;
      end else if (ar_take) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_word;
         rresp_q  <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (i_s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign o_s_axi_bvalid = bvalid_q;
   assign o_s_axi_bresp  = bresp_q;
   assign o_s_axi_rvalid = rvalid_q;
   assign o_s_axi_rdata  = rdata_q;
   assign o_s_axi_rresp  = rresp_q;

   // ==========================================================
   // shared converter scheduling
   adc_pair_conv_sched u_sched (
      .i_ref_clk      (i_ref_clk),
      .i_rst          (i_rst),
      .i_pending      (pend_q),
      .i_order        (order_q),
      .i_conv_done    (i_conv_done),
      .o_conv_start   (o_conv_start),
      .o_conv_channel (o_conv_channel),
      .o_pair_done    (pair_done),
      .o_busy         (o_conv_busy)
   );

   // ==========================================================
   // interrupt output
   assign o_irq = |(irq_stat_q & irq_mask_q);

endmodule : adc_pair_trigger_control

`default_nettype wire

// file: verification/conv_model.sv
// behavioural shared converter that answers every start after a fixed latency
`timescale 1ns/10ps
`default_nettype none

module conv_model #(
   parameter int LAT = 8
) (
   input  wire logic i_ref_clk,
   input  wire logic i_rst,
   input  wire logic i_start,
   output logic      o_done
);
   int cnt_q;

   // ==========================================================
   // one done pulse per start, slow enough to queue other pairs
   always_ff @(posedge i_ref_clk) begin
      if (i_rst || i_start) cnt_q <= i_start ? LAT : 0;
      else if (cnt_q > 0) cnt_q <= cnt_q - 1;
      o_done <= !i_rst && (cnt_q == 1);
   end
endmodule : conv_model
`default_nettype wire

// file: verification/adc_pair_trigger_checker.sv
// port assertions of the pair trigger control
`timescale 1ns/10ps
`default_nettype none

module adc_pair_trigger_checker (
   input wire logic       i_ref_clk,
   input wire logic       i_rst,
   input wire logic       o_s_axi_awready,
   input wire logic       o_s_axi_wready,
   input wire logic       o_s_axi_bvalid,
   input wire logic       i_s_axi_bready,
   input wire logic       i_s_axi_arvalid,
   input wire logic       o_s_axi_arready,
   input wire logic       o_s_axi_rvalid,
   input wire logic       i_s_axi_rready,
   input wire logic       o_conv_start,
   input wire logic [3:0] o_conv_channel,
   input wire logic       i_conv_done,
   input wire logic       o_conv_busy,
   input wire logic       o_irq
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   // ==========================================================
   // register bus
   b_hold_a:
      assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid) else $error("bvalid lost");
   r_hold_a:
      assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid) else $error("rvalid lost");
   ar_block_a:
      assert property (o_s_axi_rvalid |-> !o_s_axi_arready) else $error("arready while rvalid");
   r_answer_a:
      assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid) else $error("no read answer");
   w_block_a:
      assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready) else $error("write taken early");

   // ==========================================================
   // converter and interrupt
   start_pulse_a:
      assert property (o_conv_start |=> !o_conv_start && o_conv_busy) else $error("start not a pulse");
   chan_hold_a:
      assert property ($changed(o_conv_channel) |-> o_conv_start) else $error("channel moved");
   chan_range_a:
      assert property (o_conv_start |-> o_conv_channel < 4'h8) else $error("channel out of range");
   irq_cause_a:
      assert property ($rose(o_irq) |-> $past(i_conv_done) || $rose(o_s_axi_bvalid))
         else $error("irq without cause");
   rst_quiet_a:
      assert property ($fell(i_rst) |-> !o_irq && !o_conv_busy && !o_s_axi_bvalid)
         else $error("not idle after reset");
endmodule : adc_pair_trigger_checker

bind adc_pair_trigger_control adc_pair_trigger_checker u_adc_pair_trigger_checker (
   .i_ref_clk, .i_rst, .o_s_axi_awready, .o_s_axi_wready, .o_s_axi_bvalid, .i_s_axi_bready,
   .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rvalid, .i_s_axi_rready, .o_conv_start,
   .o_conv_channel, .i_conv_done, .o_conv_busy, .o_irq);
`default_nettype wire

// file: verification/test_adc_pair_trigger_control.sv
// self-checking bench of the pair trigger control
`timescale 1ns/10ps
`default_nettype none
`include "adc_pair_trigger_cfg.svh"

module test_adc_pair_trigger_control;
   import adc_pair_trigger_pkg::*;
   logic            i_ref_clk = 1'b0;
   logic            i_rst     = 1'b1;
   logic      [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic     [31:0] wdata  = 32'h0, rd_q;
   logic      [3:0] wstrb  = 4'h0;
   logic            awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic     [14:0] ev     = 15'h0;
   logic      [1:0] resp;
   logic      [3:0] chans[$];
   wire logic       awready, wready, bvalid, arready, rvalid, start, busy, done, irq;
   wire logic [1:0] bresp, rresp;
   wire logic[31:0] rdata;
   wire logic [3:0] chan;
   int              failures = 0, tests_run = 0, k;
   logic            hit;

   adc_pair_trigger_control u_adc_pair_trigger_control (
      .i_ref_clk, .i_rst, .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
      .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
      .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
      .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
      .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
      .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
      .i_pwm_special(ev[0]), .i_pwm_trig(ev[4:1]), .i_tmr_period(ev[6:5]),
      .i_pwm_ilim(ev[10:7]), .i_pwm_fault(ev[14:11]), .o_conv_start(start),
      .o_conv_channel(chan), .i_conv_done(done), .o_conv_busy(busy), .o_irq(irq));
   conv_model u_conv_model (.i_ref_clk, .i_rst, .i_start(start), .o_done(done));

   always #5 i_ref_clk = ~i_ref_clk;
   always @(negedge i_ref_clk) if (start) chans.push_back(chan);

   // ==========================================================
   // checks and closing
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : finish_test

   // ==========================================================
   // bus tasks
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic ta, tw, tb;
      @(posedge i_ref_clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 30; n++) begin
         @(negedge i_ref_clk);
         ta = awready;
         tw = wready;
         tb = bvalid;
         resp = bresp;
         @(posedge i_ref_clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) begin
            bready <= 1'b0;
            return;
         end
      end
      failures++;
      finish_test();
   endtask : wr

   task automatic rd(input logic [7:0] a);
      logic ta, tr;
      @(posedge i_ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 30; n++) begin
         @(negedge i_ref_clk);
         ta = arready;
         tr = rvalid;
         rd_q = rdata;
         resp = rresp;
         @(posedge i_ref_clk);
         if (ta) arvalid <= 1'b0;
         if (tr) begin
            rready <= 1'b0;
            return;
         end
      end
      failures++;
      finish_test();
   endtask : rd

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(rd_q, exp);
   endtask : rdc

   task automatic pulse(input logic [14:0] v);
      @(posedge i_ref_clk);
      ev <= v;
      @(posedge i_ref_clk);
      ev <= 15'h0;
   endtask : pulse

   task automatic wait_irq(input logic e);
      for (int n = 0; n < 60 && !irq; n++) @(negedge i_ref_clk);
      chk(irq, e);
      if (e && irq !== 1'b1) finish_test();
   endtask : wait_irq

   // event bit of a hardware source code, -1 where the code has none
   function automatic int idx(input int c);
      if (c == 3) return 0;
      if (c >= 4 && c <= 7) return c - 3;
      if (c >= 12 && c <= 17) return c - 7;
      if (c >= 22 && c <= 25) return c - 11;
      return -1;
   endfunction : idx

   // ==========================================================
   // test sequence
   initial begin
      repeat (10) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      rdc(`OFF_PAIR_LOW, 32'h0);
      rdc(`OFF_PAIR_MID, 32'h0);
      rdc(`OFF_IRQ_STATUS, 32'h0);
      rd(8'h20);
      chk(resp, `RESP_SLVERR);
      wr(8'h20, 32'hFFFF_FFFF, 4'hF);
      chk(resp, `RESP_SLVERR);
      $display("test reset and map done");

      wr(`OFF_IRQ_MASK, 32'h1, 4'h1);
      for (int c = 0; c < 32; c++) begin
         k = idx(c);
         hit = (k >= 0) || c == 1 || c == 2;
         wr(`OFF_PAIR_LOW, 32'h80 | c, 4'h1);
         pulse(15'h7FFF & ~(k >= 0 ? 15'h1 << k : 15'h0));
         wait_irq(1'b0);
         chans.delete();
         if (k >= 0) pulse(15'h1 << k);
         else if (c == 2) wr(`OFF_GLOBAL_CTRL, 32'h400, 4'h2);
         else wr(`OFF_PAIR_LOW, 32'hA0 | c, 4'h1);
         if (c == 1) rdc(`OFF_PAIR_LOW, 32'hC1);
         wait_irq(hit);
         chk(32'(chans.size()), hit ? 32'h2 : 32'h0);
         rdc(`OFF_PAIR_LOW, hit ? 32'h80 | c : 32'hA0 | c);
         if (c == 2) wr(`OFF_GLOBAL_CTRL, 32'h0, 4'h2);
         wr(`OFF_IRQ_STATUS, 32'h1, 4'h1);
         chk(irq, 1'b0);
      end
      $display("test source codes done");

      for (int o = 0; o < 2; o++) begin
         wr(`OFF_IRQ_MASK, 32'h0, 4'h1);
         wr(`OFF_GLOBAL_CTRL, 32'(o) << 6, 4'h1);
         wr(`OFF_PAIR_LOW, 32'h8484, 4'h3);
         wr(`OFF_PAIR_MID, o ? 32'h0404 : 32'h8484, 4'h3);
         chans.delete();
         pulse(15'h2);
         for (int n = 0; n < 400 && chans.size() < 8; n++) @(negedge i_ref_clk);
         if (chans.size() < 8) begin
            failures++;
            finish_test();
         end
         for (int i = 0; i < 8; i++) chk(chans[i], i ^ o);
         for (int n = 0; n < 100 && busy !== 1'b0; n++) @(negedge i_ref_clk);
         if (busy !== 1'b0) begin
            failures++;
            finish_test();
         end
         rdc(`OFF_IRQ_STATUS, o ? 32'h3 : 32'hF);
         rdc(`OFF_PAIR_MID, o ? 32'h0404 : 32'h8484);
         chk(irq, 1'b0);
         wr(`OFF_IRQ_MASK, 32'hF, 4'h1);
         chk(irq, 1'b1);
         wr(`OFF_IRQ_STATUS, 32'hF, 4'h1);
         chk(irq, 1'b0);
      end
      $display("test queue and order done");
      finish_test();
   end
endmodule : test_adc_pair_trigger_control
`default_nettype wire
